// >>> capture_pkg.sv
// Package with register map, field layout, mode codes and constants of the event capture unit.
package capture_pkg;

	// Number of independent capture channels.
	localparam int channel_count = 2;

	// Register byte offsets on the APB bus, one aligned word each.
	localparam logic [7:0] control_one_offset = 8'h00;
	localparam logic [7:0] source_one_offset = 8'h04;
	localparam logic [7:0] value_one_offset = 8'h08;
	localparam logic [7:0] control_two_offset = 8'h10;
	localparam logic [7:0] source_two_offset = 8'h14;
	localparam logic [7:0] value_two_offset = 8'h18;
	localparam logic [7:0] status_offset = 8'h20;
	localparam logic [7:0] mask_offset = 8'h24;

	// Address bits used by the decoder.
	localparam int addr_width = 8;

	// Field positions in the control register.
	localparam int enable_bit = 7;
	localparam int alignment_bit = 4;
	localparam int mode_lsb = 0;
	localparam int mode_width = 4;

	// Source select field width in the source register.
	localparam int source_width = 2;

	// Reset values of the software registers.
	localparam logic [7:0] control_reset = 8'h00;
	localparam logic [1:0] source_reset = 2'h0;
	localparam logic [1:0] mask_reset = 2'h0;

	// Writable bits of the control register; the rest read as zero.
	localparam logic [7:0] control_write_mask = 8'h9f;

	// Capture mode encodings of the mode field.
	typedef enum logic [3:0] {
		mode_off = 4'h0,
		mode_any_edge = 4'h3,
		mode_fall = 4'h4,
		mode_rise = 4'h5,
		mode_rise_4 = 4'h6,
		mode_rise_16 = 4'h7
	} capture_mode_t;

	// Capture source encodings of the source field.
	typedef enum logic [1:0] {
		source_pin = 2'h0,
		source_comp_one = 2'h1,
		source_comp_two = 2'h2,
		source_pin_change = 2'h3
	} capture_source_t;

	// Prescaler terminal counts for the divided rising-edge modes.
	localparam logic [3:0] prescale_last_4 = 4'h3;
	localparam logic [3:0] prescale_last_16 = 4'hf;
	localparam logic [3:0] prescale_zero = 4'h0;
	localparam logic [3:0] prescale_step = 4'h1;

	// Width of the captured timer value.
	localparam int value_width = 16;

endpackage

// >>> capture_channel_if.sv
// Interface carrying one capture channel's settings and results.
`timescale 1ns/100ps
interface capture_channel_if;
	import capture_pkg::*;

	logic [7:0] control; // Control register contents.
	logic [1:0] source; // Source select field.
	logic [value_width-1:0] value; // Captured timer value.
	logic capture; // One-cycle capture strobe.

	// The register file drives settings and reads results.
	modport regs (output control, output source, input value, input capture);
	// The channel reads settings and drives results.
	modport chan (input control, input source, output value, output capture);
endinterface // capture_channel_if

// >>> capture_channel.sv
// One capture channel: source select, edge detect, prescaler and value latch.
`timescale 1ns/100ps
module capture_channel
	import capture_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic pin_in,
	input wire logic comp_one_sync,
	input wire logic comp_two_sync,
	input wire logic pin_change,
	input wire logic [value_width-1:0] timer_count,
	capture_channel_if.chan ch
);

	// Previous sample of the selected source.
	logic prev_sample;
	// Edge prescaler count.
	logic [3:0] prescale;
	// Captured value and strobe registers.
	logic [value_width-1:0] value;
	logic capture;

	// Source selection.
	wire [1:0] sel = ch.source;
	wire sample = (sel == source_pin) ? pin_in :
		(sel == source_comp_one) ? comp_one_sync :
		(sel == source_comp_two) ? comp_two_sync : pin_change;

	// Mode decode; only the documented capture codes count as capture mode.
	wire [3:0] mode = ch.control[mode_lsb +: mode_width];
	wire enabled = ch.control[enable_bit];
	wire is_capture = (mode == mode_any_edge) || (mode == mode_fall) || (mode == mode_rise) ||
		(mode == mode_rise_4) || (mode == mode_rise_16);
	wire active = enabled && is_capture;

	// Edges against the previous clock sample.
	wire rise = sample && !prev_sample;
	wire fall = !sample && prev_sample;

	// Prescaler terminal count for the divided modes.
	wire [3:0] last = (mode == mode_rise_16) ? prescale_last_16 : prescale_last_4;
	wire divided = (mode == mode_rise_4) || (mode == mode_rise_16);
	wire prescale_done = (prescale >= last);

	// Event qualification per mode.
	wire event_hit = active && (
		((mode == mode_any_edge) && (rise || fall)) ||
		((mode == mode_fall) && fall) ||
		((mode == mode_rise) && rise) ||
		(divided && rise && prescale_done));

	// Prescaler next value: steps on divided-mode rising edges, else held; cleared when not active.
	wire [3:0] next_prescale = !active ? prescale_zero :
		(divided && rise) ? (prescale_done ? prescale_zero : 4'(prescale + prescale_step)) : prescale;

	// Sample history and prescaler.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_sample <= 1'b0;
			prescale <= prescale_zero;
		end else if (clk_en) begin
			prev_sample <= sample;
			prescale <= next_prescale;
		end
	end

	// Value latch overwrites on every event; strobe lasts one clock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value <= '0;
			capture <= 1'b0;
		end else if (clk_en) begin
			capture <= event_hit;
			if (event_hit) begin
				value <= timer_count;
			end
		end
	end

	assign ch.value = value;
	assign ch.capture = capture;

endmodule // capture_channel

// >>> timer_event_capture_unit.sv
// Top of the event capture unit: APB register file, two channels and interrupt.
// Behaviour
// - Event copies 16-bit base timer into value.
// - Mode picks any, falling, rising, 4th, 16th.
// - Source select picks pin, comparators, pin-change.
// - Every capture sets the channel event flag.
// - Flag stays set until software clears it.
// - New capture overwrites old value, no lockout.
// - Two independent identical channels exist.
// - Prescaler clears when off, non-capture, reset.
// - Capture output pulses one clock per capture.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module timer_event_capture_unit
	import capture_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [addr_width-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [channel_count-1:0] capture_pin,
	input wire logic comparator_one_sync_out,
	input wire logic comparator_two_sync_out,
	input wire logic pin_change_trigger,
	input wire logic [value_width-1:0] base_timer_count,
	output logic [channel_count-1:0] capture_out,
	output logic irq
);

	// Decodes an APB offset into a register selector; used for reads and writes.
	function automatic logic [3:0] decode(input logic [addr_width-1:0] a);
		case (a)
			control_one_offset: decode = 4'h1;
			source_one_offset: decode = 4'h2;
			value_one_offset: decode = 4'h3;
			control_two_offset: decode = 4'h4;
			source_two_offset: decode = 4'h5;
			value_two_offset: decode = 4'h6;
			status_offset: decode = 4'h7;
			mask_offset: decode = 4'h8;
			default: decode = 4'h0;
		endcase
	endfunction

	// Channel connections, one interface per channel.
	capture_channel_if chan_bus[channel_count]();

	// Software registers per channel.
	logic [7:0] control [channel_count];
	logic [1:0] source [channel_count];
	// Sticky event flags and their mask.
	logic [channel_count-1:0] status;
	logic [channel_count-1:0] mask;
	// Strobe collected from the channels.
	wire [channel_count-1:0] capture_hit;
	// Captured values collected for readback.
	wire [value_width-1:0] chan_value [channel_count];

	// Bus phase decode; the slave answers in the second access cycle, after one wait state.
	wire access = psel && penable;
	wire [3:0] reg_sel = decode(paddr);
	wire unmapped = (reg_sel == 4'h0);
	wire wr = access && pwrite && !unmapped && clk_en;
	wire rd = access && !pwrite && !unmapped && clk_en;
	// Clear only at the edge that loads the read data, so a capture landing in the
	// answer cycle is not wiped out before software has seen it.
	wire status_read = rd && !pready && (reg_sel == 4'h7);

	// Two channels built from one description.
	genvar g;
	generate
		for (g = 0; g < channel_count; g++) begin : gen_chan
			assign chan_bus[g].control = control[g];
			assign chan_bus[g].source = source[g];
			assign capture_hit[g] = chan_bus[g].capture;
			assign chan_value[g] = chan_bus[g].value;

			capture_channel u_chan (
				.pclk(pclk),
				.presetn(presetn),
				.clk_en(clk_en),
				.pin_in(capture_pin[g]),
				.comp_one_sync(comparator_one_sync_out),
				.comp_two_sync(comparator_two_sync_out),
				.pin_change(pin_change_trigger),
				.timer_count(base_timer_count),
				.ch(chan_bus[g])
			);

			// Per-channel write decode for control and source.
			wire ctl_hit = wr && (reg_sel == ((g == 0) ? 4'h1 : 4'h4));
			wire src_hit = wr && (reg_sel == ((g == 0) ? 4'h2 : 4'h5));

			// Control and source registers steer the channel.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					control[g] <= control_reset;
					source[g] <= source_reset;
				end else begin
					if (ctl_hit) begin
						control[g] <= pwdata[7:0] & control_write_mask;
					end
					if (src_hit) begin
						source[g] <= pwdata[source_width-1:0];
					end
				end
			end

			// Event flag: a capture sets it, a status read clears it, set wins.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					status[g] <= 1'b0;
				end else if (clk_en) begin
					if (capture_hit[g]) begin
						status[g] <= 1'b1;
					end else if (status_read) begin
						status[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Value readback, honouring the alignment bit for a left-justified view.
	function automatic logic [31:0] value_word(input logic [value_width-1:0] v, input logic left);
		value_word = left ? {v, 16'h0000} : {16'h0000, v};
	endfunction

	// Read data selection.
	wire [31:0] read_mux =
		(reg_sel == 4'h1) ? {24'h000000, control[0]} :
		(reg_sel == 4'h2) ? {30'h00000000, source[0]} :
		(reg_sel == 4'h3) ? value_word(chan_value[0], control[0][alignment_bit]) :
		(reg_sel == 4'h4) ? {24'h000000, control[1]} :
		(reg_sel == 4'h5) ? {30'h00000000, source[1]} :
		(reg_sel == 4'h6) ? value_word(chan_value[1], control[1][alignment_bit]) :
		(reg_sel == 4'h7) ? {30'h00000000, status} :
		(reg_sel == 4'h8) ? {30'h00000000, mask} : 32'h00000000;

	// Mask register write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= mask_reset;
		end else if (wr && (reg_sel == 4'h8)) begin
			mask <= pwdata[channel_count-1:0];
		end
	end

	// APB answer: registered data, one wait state, error on unmapped access.
	// The registered answer keeps every output straight from a flip-flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= access && !pready;
			pslverr <= access && !pready && unmapped;
			prdata <= (psel && !pwrite && !pready) ? read_mux : 32'h00000000;
		end
	end

	// Registered strobe out and level interrupt.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_out <= '0;
			irq <= 1'b0;
		end else if (clk_en) begin
			capture_out <= capture_hit;
			irq <= |((status | capture_hit) & mask & ~({channel_count{status_read}} & ~capture_hit));
		end
	end

endmodule // timer_event_capture_unit

// >>> event_source.sv
// Model of the event sources and base timer that feed the capture unit.
`timescale 1ns/100ps
module event_source
	import capture_pkg::*;
(
	input wire logic pclk,
	output logic [1:0] capture_pin,
	output logic comparator_one_sync_out,
	output logic comparator_two_sync_out,
	output logic pin_change_trigger,
	output logic [value_width-1:0] base_timer_count
);
	logic [4:0] lvl = 5'h00; // Bits 1:0 pins, 2 and 3 comparators, 4 pin change.
	logic [15:0] count = 16'h0000; // Timer value, held steady while an event settles.
	assign {pin_change_trigger, comparator_two_sync_out, comparator_one_sync_out, capture_pin} = lvl;
	assign base_timer_count = count;
	// Levels move only just after a rising edge, as synchronised sources do.
	task automatic set_level(input int idx, input logic val, input logic [15:0] t);
		@(posedge pclk);
		lvl[idx] <= val;
		count <= t;
	endtask
endmodule // event_source

// >>> timer_event_capture_unit_properties.sv
// Port-level assertions for the event capture unit.
`timescale 1ns/100ps
module timer_event_capture_unit_properties
	import capture_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [addr_width-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [channel_count-1:0] capture_pin,
	input wire logic comparator_one_sync_out,
	input wire logic comparator_two_sync_out,
	input wire logic pin_change_trigger,
	input wire logic [value_width-1:0] base_timer_count,
	input wire logic [channel_count-1:0] capture_out,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Accesses that may clear the flags or change the mask.
	wire clr = psel && penable && (pwrite ? paddr == mask_offset : paddr == status_offset);
	// Every possible source of a channel; a capture with no change on any is false.
	wire [3:0] ev0 = {capture_pin[0], comparator_one_sync_out, comparator_two_sync_out, pin_change_trigger};
	wire [3:0] ev1 = {capture_pin[1], comparator_one_sync_out, comparator_two_sync_out, pin_change_trigger};
	logic [1:0] mask_q; // Mask mirrored from completed writes.
	// The mirror follows the register so irq can be predicted.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= mask_reset;
		end else if (clr && pready && pwrite) begin
			mask_q <= pwdata[1:0];
		end
	end
	sequence access_phase; psel && !penable ##1 psel && penable && clk_en; endsequence
	sequence pulse0; $rose(capture_out[0]); endsequence
	sequence pulse1; $rose(capture_out[1]); endsequence
	AST_READY_WAIT: assert property (access_phase |=> pready)
		else $error("no answer one cycle into the access phase");
	AST_READY_ONE: assert property (pready |=> !pready)
		else $error("ready held for more than one cycle");
	AST_ERR_READY: assert property (pslverr |-> pready)
		else $error("error response without ready");
	AST_PULSE_ONE: assert property (pulse0 |=> !capture_out[0])
		else $error("channel one capture pulse too long");
	AST_PULSE_TWO: assert property (pulse1 |=> !capture_out[1])
		else $error("channel two capture pulse too long");
	AST_FLAG_SET: assert property (pulse0 ##0 mask_q[0] |=> irq)
		else $error("capture did not raise the interrupt");
	AST_FLAG_HOLD: assert property ($fell(irq) |-> $past(clr))
		else $error("interrupt dropped without a status read or mask write");
	AST_EDGE_ONE: assert property (pulse0 |-> $past(ev0, 2) != $past(ev0, 3) || $past(ev0, 3) != $past(ev0, 4))
		else $error("channel one captured without a source edge");
	AST_EDGE_TWO: assert property (pulse1 |-> $past(ev1, 2) != $past(ev1, 3) || $past(ev1, 3) != $past(ev1, 4))
		else $error("channel two captured without a source edge");
endmodule // timer_event_capture_unit_properties

// >>> tb.sv
// Self-checking bench for the event capture unit.
`timescale 1ns/100ps
module tb;
	import capture_pkg::*;
	logic pclk = 1'b0; // 20 MHz system clock.
	logic presetn = 1'b0;
	logic clk_en = 1'b1; // Held high: freezing is not exercised here.
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, comparator_one_sync_out, comparator_two_sync_out, pin_change_trigger, irq, err_q;
	logic [1:0] capture_pin, capture_out;
	logic [15:0] base_timer_count;
	logic [15:0] tv [32]; // Timer value handed out with each source change.
	int fail_count = 0, num_checks = 0, cycles = 0;
	int caps [2] = '{0, 0}; // Capture pulses seen per channel.
	always #25 pclk = ~pclk;
	timer_event_capture_unit uut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .capture_pin, .comparator_one_sync_out, .comparator_two_sync_out, .pin_change_trigger,
		.base_timer_count, .capture_out, .irq);
	event_source src (.pclk, .capture_pin, .comparator_one_sync_out, .comparator_two_sync_out, .pin_change_trigger,
		.base_timer_count);
	// Count capture pulses and cut a hang short.
	always @(posedge pclk) begin
		cycles++;
		for (int i = 0; i < 2; i++) begin
			if (capture_out[i] === 1'b1) begin
				caps[i]++;
			end
		end
		if (cycles == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	// Captures expected from sixteen rising and sixteen falling edges.
	function automatic int exp_caps(input int m);
		case (m)
			mode_any_edge: return 32;
			mode_rise_4: return 4;
			mode_rise_16: return 1;
			default: return 16;
		endcase
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus transfer; the request is held until ready is sampled high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(q, e);
	endtask
	// Rise and fall a source n times, each with a fresh random timer value.
	task automatic pulses(input int idx, input int n);
		for (int j = 0; j < 2 * n; j++) begin
			tv[j] = 16'($urandom);
			src.set_level(idx, !j[0], tv[j]);
			repeat (4) @(posedge pclk);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		logic [7:0] base;
		void'($urandom(32'h97bd));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(control_one_offset, 32'(control_reset));
		rd_chk(source_two_offset, 32'(source_reset));
		rd_chk(mask_offset, 32'(mask_reset));
		rd_chk(8'h3c, 32'h0);
		check(32'(err_q), 32'h1);
		$display("test register defaults done");
		apb(1'b1, mask_offset, 32'h3);
		// Every channel, source and capture mode; mode 7 also uses the upper alignment.
		for (int ch = 0; ch < 2; ch++) begin
			base = 8'(ch * 16);
			for (int s = 0; s < 4; s++) begin
				for (int m = 3; m < 8; m++) begin
					apb(1'b1, control_one_offset + base, 32'h0);
					apb(1'b1, source_one_offset + base, 32'(s));
					apb(1'b1, control_one_offset + base, 32'h80 | 32'(m) | (m == 7 ? 32'h10 : 32'h0));
					caps = '{0, 0};
					pulses(s == 0 ? ch : s + 1, 16);
					repeat (4) @(posedge pclk);
					check(32'(caps[ch]), 32'(exp_caps(m)));
					check(32'(caps[1 - ch]), 32'h0);
					apb(1'b0, value_one_offset + base, 32'h0);
					check({16'h0, m == 7 ? q[31:16] : q[15:0]}, {16'h0, tv[m > 4 ? 30 : 31]});
					check(32'(irq), 32'h1);
					rd_chk(status_offset, 32'h1 << ch);
					rd_chk(status_offset, 32'h0);
					check(32'(irq), 32'h0);
					apb(1'b1, control_one_offset + base, 32'h0);
					$display("test channel %0d source %0d mode %0d done", ch, s, m);
				end
			end
		end
		// Disabling must drop a part-filled divide-by-four count.
		apb(1'b1, source_one_offset, 32'h0);
		apb(1'b1, control_one_offset, 32'h86);
		pulses(0, 2);
		apb(1'b1, control_one_offset, 32'h0);
		apb(1'b1, control_one_offset, 32'h86);
		caps = '{0, 0};
		pulses(0, 3);
		check(32'(caps[0]), 32'h0);
		pulses(0, 1);
		check(32'(caps[0]), 32'h1);
		$display("test prescaler clear done");
		finish_test();
	end
endmodule // tb
bind timer_event_capture_unit timer_event_capture_unit_properties chk (.pclk, .presetn, .clk_en, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .capture_pin, .comparator_one_sync_out,
	.comparator_two_sync_out, .pin_change_trigger, .base_timer_count, .capture_out, .irq);
